/* File: hw/conv_rate_pkg.sv */
package conv_rate_pkg;

   // register location and width
   localparam logic [7:0] CFG_OFFSET   = 8'h04;
   localparam int         CFG_W        = 8;
   localparam logic [7:0] CFG_RESET    = 8'h14;

   // field positions
   localparam int         RSVD_HI_BIT  = 7;
   localparam int         CLK_SEL_BIT  = 6;
   localparam int         MODE_BIT     = 5;
   localparam int         RSVD_LO_BIT  = 4;
   localparam int         RATE_LSB     = 0;
   localparam int         RATE_W       = 4;

   // rate code values
   localparam logic [3:0] RATE_DEFAULT = 4'h4;
   localparam logic [3:0] RATE_RSVD    = 4'hf;

   // value expected by hardware in the reserved bits
   localparam logic       RSVD_HI_VAL  = 1'b0;
   localparam logic       RSVD_LO_VAL  = 1'b1;

   // conversion clock source
   typedef enum logic [0:0] {
      CLK_INTERNAL = 1'b0,
      CLK_EXTERNAL = 1'b1
   } clk_src_t;

   // conversion mode
   typedef enum logic [0:0] {
      MODE_CONTINUOUS  = 1'b0,
      MODE_SINGLE_SHOT = 1'b1
   } conv_mode_t;

endpackage : conv_rate_pkg

/* File: hw/conversion_rate_config_reg.sv */
// Overview of operation
// RQ1: register sits at offset 04h and resets to 14h.
// RQ2: bit 6 picks clock source; 0 internal oscillator, 1 external clock.
// RQ3: bit 5 picks conversion mode; 0 continuous, 1 single-shot.
// RQ4: host writes 1 to bit 4 and 0 to bit 7; both stored.
// RQ5: bits 3 to 0 hold output rate code; reset code 4h.
// RQ6: reserved rate code 1111 is stored as written, no rate promised.
module conversion_rate_config_reg
   import conv_rate_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input  wire logic              clock_i,
   input  wire logic              nrst_i,
   input  wire logic              wr_en_i,
   input  wire logic              rd_en_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [CFG_W-1:0]  wdata_i,
   output logic      [CFG_W-1:0]  rdata_o,
   output logic                   rd_hit_o,
   output logic                   clk_select_o,
   output logic                   single_shot_o,
   output logic      [RATE_W-1:0] output_rate_code_o,
   output logic                   rate_reserved_o,
   output logic                   rate_rsvd_seen_o,
   output logic                   rsvd_bits_bad_o,
   output logic                   cfg_changed_o
);

   // elaboration check on the address width
   if (ADDR_W < 3 || ADDR_W > 16) begin : g_addr_check
      $error("ADDR_W must lie between 3 and 16");
   end

   localparam logic [ADDR_W-1:0] OFFS = ADDR_W'(CFG_OFFSET);

   // address decode shared by the read and write paths
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      addr_hit = (a == OFFS);
   endfunction : addr_hit

   logic [CFG_W-1:0] cfg_q;
   logic [CFG_W-1:0] cfg_d;
   logic [CFG_W-1:0] rdata_q;
   logic             rd_hit_q;
   logic             rsvd_bad_q;
   logic             changed_q;
   logic             wr_hit;
   logic             rd_hit;
   clk_src_t         clk_src;
   conv_mode_t       conv_mode;

   assign wr_hit = wr_en_i && addr_hit(addr_i);
   assign rd_hit = rd_en_i && addr_hit(addr_i);

   // next value: the whole byte is stored, reserved bits included
   always_comb begin
      cfg_d = cfg_q;
      if (wr_hit) begin
         cfg_d = wdata_i; // RQ4 RQ6
      end
   end

   // configuration register
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_q <= CFG_RESET; // RQ1
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // read answer, old value when read and write share a cycle
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q  <= '0;
         rd_hit_q <= 1'b0;
      end else begin
         rd_hit_q <= rd_hit; // RQ1
         if (rd_hit) begin
            rdata_q <= cfg_q;
         end else begin
            rdata_q <= '0; // unmapped or idle reads give zero
         end
      end
   end

   // pulse when a write alters the stored value
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         changed_q <= 1'b0;
      end else begin
         changed_q <= wr_hit && (wdata_i != cfg_q);
      end
   end

   // level flag: reserved bits hold other than their fixed values
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rsvd_bad_q <= 1'b0;
      end else begin
         rsvd_bad_q <= (cfg_d[RSVD_HI_BIT] != RSVD_HI_VAL) ||
                       (cfg_d[RSVD_LO_BIT] != RSVD_LO_VAL);
      end
   end

   // decoded fields for the converter core
   assign clk_src   = clk_src_t'(cfg_q[CLK_SEL_BIT]); // RQ2
   assign conv_mode = conv_mode_t'(cfg_q[MODE_BIT]);  // RQ3

   // reserved rate code detection
   rate_code_check u_rate_check (
      .clock_i     (clock_i),
      .nrst_i      (nrst_i),
      .code_i      (cfg_q[RATE_LSB +: RATE_W]),
      .reserved_o  (rate_reserved_o),
      .used_rsvd_o (rate_rsvd_seen_o)
   );

   // outputs straight from flops
   assign rdata_o            = rdata_q;
   assign rd_hit_o           = rd_hit_q;
   assign clk_select_o       = (clk_src == CLK_EXTERNAL);       // RQ2
   assign single_shot_o      = (conv_mode == MODE_SINGLE_SHOT); // RQ3
   assign output_rate_code_o = cfg_q[RATE_LSB +: RATE_W];       // RQ5
   assign rsvd_bits_bad_o    = rsvd_bad_q;
   assign cfg_changed_o      = changed_q;

   // assertions

   // write to this register at the documented offset
   sequence wr_seq;
      wr_en_i && (addr_i == OFFS);
   endsequence

   sequence wr_rsvd_code_seq;
      wr_seq ##0 (wdata_i[RATE_LSB +: RATE_W] == RATE_RSVD);
   endsequence

   // reset value seen on the first edge after release
   reset_value_a : assert property ( // RQ1
      @(posedge clock_i) disable iff (!nrst_i)
      !$past(nrst_i) |-> (cfg_q == CFG_RESET) && !clk_select_o &&
                         !single_shot_o &&
                         (output_rate_code_o == RATE_DEFAULT))
      else $error("register not at reset value after reset");

   // clock source follows written bit 6
   clk_source_a : assert property ( // RQ2
      @(posedge clock_i) disable iff (!nrst_i)
      wr_seq |=> (clk_select_o == $past(wdata_i[CLK_SEL_BIT])))
      else $error("clock source does not follow bit 6");

   // conversion mode follows written bit 5
   conv_mode_a : assert property ( // RQ3
      @(posedge clock_i) disable iff (!nrst_i)
      wr_seq |=> (single_shot_o == $past(wdata_i[MODE_BIT])))
      else $error("conversion mode does not follow bit 5");

   // rate code follows written low nibble
   rate_code_a : assert property ( // RQ5
      @(posedge clock_i) disable iff (!nrst_i)
      wr_seq |=> (output_rate_code_o == $past(wdata_i[RATE_W-1:0])))
      else $error("rate code does not follow bits 3 to 0");

   // reserved bits stored as written
   rsvd_store_a : assert property ( // RQ4
      @(posedge clock_i) disable iff (!nrst_i)
      wr_seq |=> (cfg_q[RSVD_HI_BIT] == $past(wdata_i[RSVD_HI_BIT])) &&
                 (cfg_q[RSVD_LO_BIT] == $past(wdata_i[RSVD_LO_BIT])))
      else $error("reserved bits not stored as written");

   // reserved rate code stored one cycle on and flagged two cycles on
   rsvd_code_a : assert property ( // RQ6
      @(posedge clock_i) disable iff (!nrst_i)
      wr_rsvd_code_seq |=> (output_rate_code_o == RATE_RSVD)
                           ##1 (rate_reserved_o && rate_rsvd_seen_o))
      else $error("reserved rate code not stored or flagged");

   // read returns the stored value one cycle later
   read_back_a : assert property ( // RQ1
      @(posedge clock_i) disable iff (!nrst_i)
      (rd_en_i && (addr_i == OFFS)) |=> rd_hit_o &&
                                        (rdata_o == $past(cfg_q)))
      else $error("read back does not match register");

   // other offsets neither answer nor disturb the register
   unmapped_a : assert property ( // RQ1
      @(posedge clock_i) disable iff (!nrst_i)
      (addr_i != OFFS) |=> !rd_hit_o && (rdata_o == '0) &&
                           $stable(cfg_q))
      else $error("unmapped offset reached the register");

   // register holds without a write
   hold_value_a : assert property ( // RQ5
      @(posedge clock_i) disable iff (!nrst_i)
      !wr_en_i [*2] |=> $stable(output_rate_code_o) && $stable(cfg_q))
      else $error("register changed without a write");

   // reserved-bit flag follows the stored byte
   rsvd_flag_a : assert property ( // RQ4
      @(posedge clock_i) disable iff (!nrst_i)
      wr_seq |=> (rsvd_bits_bad_o ==
                  (($past(wdata_i[RSVD_HI_BIT]) != RSVD_HI_VAL) ||
                   ($past(wdata_i[RSVD_LO_BIT]) != RSVD_LO_VAL))))
      else $error("reserved bit flag does not follow the write");

   // write whose data differ from the stored byte
   sequence wr_alter_seq;
      wr_seq ##0 (wdata_i != cfg_q);
   endsequence

   // altering write gives a change pulse one cycle on
   change_pulse_a : assert property ( // RQ1
      @(posedge clock_i) disable iff (!nrst_i)
      wr_alter_seq |=> cfg_changed_o)
      else $error("altering write gave no change pulse");

   // no change pulse without a write
   change_quiet_a : assert property ( // RQ1
      @(posedge clock_i) disable iff (!nrst_i)
      !wr_en_i |=> !cfg_changed_o)
      else $error("change pulse without a write");

   // reserved code flag low while a valid code is stored
   rsvd_clear_a : assert property ( // RQ6
      @(posedge clock_i) disable iff (!nrst_i)
      (output_rate_code_o != RATE_RSVD) |=> !rate_reserved_o)
      else $error("reserved code flag without reserved code");

   // read answer lasts one cycle unless read again
   read_pulse_a : assert property ( // RQ1
      @(posedge clock_i) disable iff (!nrst_i)
      !rd_en_i |=> !rd_hit_o && (rdata_o == '0))
      else $error("read answer outlived its cycle");

endmodule : conversion_rate_config_reg

/* File: hw/rate_code_check.sv */
module rate_code_check
   import conv_rate_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              nrst_i,
   input  wire logic [RATE_W-1:0] code_i,
   output logic                   reserved_o,
   output logic                   used_rsvd_o
);

   logic reserved_q;
   logic used_rsvd_q;

   // flag the one code that selects no conversion rate
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reserved_q <= 1'b0;
      end else begin
         reserved_q <= (code_i == RATE_RSVD); // RQ6
      end
   end

   // sticky record that the reserved code was seen since reset
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         used_rsvd_q <= 1'b0;
      end else if (code_i == RATE_RSVD) begin
         used_rsvd_q <= 1'b1;
      end
   end

   assign reserved_o  = reserved_q;
   assign used_rsvd_o = used_rsvd_q;

endmodule : rate_code_check

/* File: verification/host_model.sv */
module host_model (
   input  wire logic       clock_i,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rd_hit_i,
   output logic            wr_en_o,
   output logic            rd_en_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // bus idle at time zero
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o  = 8'h00;
      wdata_o = 8'h00;
   end

   // one write; reserved bits forced unless raw asked
   task automatic write(input logic [7:0] a, input logic [7:0] d,
                        input bit raw);
      @(posedge clock_i);
      wr_en_o <= 1'b1;
      addr_o  <= a;
      wdata_o <= raw ? d : {1'b0, d[6:5], 1'b1, d[3:0]};
      @(posedge clock_i);
      wr_en_o <= 1'b0;
      wdata_o <= ~d;  // stale data, no longer valid
   endtask : write

   // one read; answer taken one cycle after the request
   task automatic read(input logic [7:0] a, output logic [7:0] d,
                       output logic h);
      @(posedge clock_i);
      rd_en_o <= 1'b1;
      addr_o  <= a;
      @(posedge clock_i);
      rd_en_o <= 1'b0;
      #1;
      d = rdata_i;
      h = rd_hit_i;
   endtask : read
endmodule : host_model

/* File: verification/testbench.sv */
module testbench
   import conv_rate_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clock_i, nrst_i, wr_en, rd_en;
   logic [7:0] addr, wdata, rdata, cfg_m, d;
   logic       hit, clk_sel, sshot, rres, rseen, rbad, chg;
   logic [3:0] rate;
   logic       hit_s;
   int         miscompares = 0;
   int         compares = 0;

   conversion_rate_config_reg conversion_rate_config_reg_inst (
      .clock_i(clock_i), .nrst_i(nrst_i), .wr_en_i(wr_en),
      .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata),
      .rdata_o(rdata), .rd_hit_o(hit), .clk_select_o(clk_sel),
      .single_shot_o(sshot), .output_rate_code_o(rate),
      .rate_reserved_o(rres), .rate_rsvd_seen_o(rseen),
      .rsvd_bits_bad_o(rbad), .cfg_changed_o(chg));

   host_model host_model_inst (
      .clock_i(clock_i), .rdata_i(rdata), .rd_hit_i(hit),
      .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
      .wdata_o(wdata));

   // 100 mhz clock
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   // field outputs against the model value
   task automatic chk_fields();
      check("clk_sel", {7'h00, clk_sel}, {7'h00, cfg_m[6]});
      check("sshot", {7'h00, sshot}, {7'h00, cfg_m[5]});
      check("rate", {4'h0, rate}, {4'h0, cfg_m[3:0]});
      check("rbad", {7'h00, rbad}, {7'h00, cfg_m[7] | ~cfg_m[4]});
   endtask : chk_fields

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      host_model_inst.read(a, d, hit_s);
      check("rdata", d, exp);
      check("hit", {7'h00, hit_s}, {7'h00, a == CFG_OFFSET});
   endtask : rd_reg

   // watchdog
   initial begin
      #200000;
      miscompares++;
      finish_test();
   end

   initial begin
      nrst_i = 1'b0;
      cfg_m = CFG_RESET;
      void'($urandom(32'h948787bb));
      repeat (16) @(posedge clock_i);
      nrst_i <= 1'b1;
      #1;
      chk_fields();
      rd_reg(CFG_OFFSET, 8'h14);
      $display("reset test done");
      // every rate code with random clock and mode bits
      for (int i = 0; i < 16; i++) begin
         d = {1'b0, 2'($urandom()), 1'b1, 4'(i)};
         host_model_inst.write(CFG_OFFSET, d, 1'b0);
         #1;
         check("chg", {7'h00, chg}, {7'h00, d != cfg_m});
         cfg_m = d;
         chk_fields();
         @(posedge clock_i);
         #1;
         check("rres", {7'h00, rres}, {7'h00, i == 15});
         rd_reg(CFG_OFFSET, cfg_m);
      end
      check("rseen", {7'h00, rseen}, 8'h01);
      $display("rate code test done");
      // unmapped address leaves the register alone
      host_model_inst.write(8'h05, 8'h00, 1'b1);
      rd_reg(8'h05, 8'h00);
      rd_reg(CFG_OFFSET, cfg_m);
      $display("unmapped test done");
      // reserved bits stored as written
      host_model_inst.write(CFG_OFFSET, 8'he0, 1'b1);
      cfg_m = 8'he0;
      #1;
      chk_fields();
      rd_reg(CFG_OFFSET, cfg_m);
      $display("reserved bit test done");
      // reset in mid-run
      @(posedge clock_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      cfg_m = CFG_RESET;
      #1;
      chk_fields();
      check("rseen", {7'h00, rseen}, 8'h00);
      rd_reg(CFG_OFFSET, 8'h14);
      $display("second reset test done");
      finish_test();
   end
endmodule : testbench
